//--- design/sdram_bank_command_timing.sv
// What this block does
// - power-down request during a burst enters clock suspend instead
// - commands use only the previous clock-gate sample; exit needs low then high
// - open-row command activates idle selected bank and latches 12-bit row
// - close-bank command idles selected bank at once; no row active window is checked
// - close-all closes all four banks, ignores bank select
// - read takes column from low eight address bits, words after latency
// - data pins released after last read word
// - full-page bursts run until cut, column wraps to zero
// - read burst can be cut by read, write or close
// - read byte masks disable outputs with two-clock latency
// - read with auto close idles bank after burst; ignored in full page
// - write takes first word on command edge, then one per edge
// - write burst can be cut by write, read or close
// - read cutting a write stops further input data
// - write with auto close idles bank after burst; ignored in full page
// - clock-gate low freezes outputs and burst state from next cycle
// - each byte mask covers one byte lane, highest mask top byte
// - chip select high masks all command and address inputs
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "sdram_defines.svh"

module sdram_bank_command_timing
  import sdram_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BANK_SEL,
  input wire logic [11:0] ADDR,
  input wire logic [3:0] DQM,
  input wire logic [31:0] DQ_IN,
  output logic [31:0] DQ_OUT,
  output logic [3:0] DQ_OE_N
);

  logic cke_prev;
  logic run;
  cmd_t cmd;
  power_t power;
  logic [`MODE_W-1:0] mode_reg;
  logic [7:0] ap_delay;
  logic [3:0] bank_active;
  logic [11:0] open_row [0:3];
  logic rd_busy;
  logic wr_busy;
  logic [1:0] b_bank;
  logic [7:0] b_start;
  logic [7:0] b_idx;
  logic b_ap;
  logic ap_on;
  logic [7:0] ap_cnt;
  logic [1:0] ap_bank;
  logic ap_close;
  logic ap_start;
  logic [1:0] ap_start_bank;
  logic full_page;
  logic last_word;
  logic close_hit;
  logic rd_cmd_ok;
  logic wr_cmd_ok;
  logic rv;
  logic wv;
  logic [9:0] raddr;
  logic [9:0] waddr;
  logic [31:0] mem_q;
  logic p1_v;
  logic p2_v;
  logic [31:0] p1_d;
  logic [31:0] p2_d;
  logic [3:0] dqm_d1;
  logic out_v;
  logic [31:0] out_d;
  logic apb_take;
  logic [31:0] status_word;

  function automatic logic [7:0] col_mask(input logic [2:0] code);
    logic [7:0] m;
    m = `MASK_FULL;
    case (code)
      `BL_1: m = `MASK_1;
      `BL_2: m = `MASK_2;
      `BL_4: m = `MASK_4;
      `BL_8: m = `MASK_8;
      default: m = `MASK_FULL;
    endcase
    return m;
  endfunction

  // column of word idx in the programmed burst order
  function automatic logic [7:0] burst_col(input logic [7:0] start, input logic [7:0] idx,
                                           input logic [2:0] code, input logic il);
    logic [7:0] m;
    logic [7:0] offs;
    m = col_mask(code);
    offs = il ? ((start & m) ^ idx) : 8'((start & m) + idx);
    return (start & ~m) | (offs & m);
  endfunction

  // internal clock runs on the edge after a high clock-gate sample
  assign run = cke_prev;

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      cke_prev <= 1'b0;
    end
    else
    begin
      cke_prev <= CKE;
    end
  end

  // command decode
  always_comb
  begin
    cmd = CMD_NOP;
    if (cke_prev && !CS_N)
    begin
      case ({RAS_N, CAS_N, WE_N})
        3'b011: cmd = CMD_OPEN;
        3'b010: cmd = CMD_CLOSE;
        3'b101: cmd = CMD_READ;
        3'b100: cmd = CMD_WRITE;
        3'b111: cmd = CMD_NOP;
        default: cmd = CMD_OTHER;
      endcase
    end
  end

  assign full_page = (mode_reg[`F_BL] == `BL_FULL);
  assign rd_cmd_ok = (cmd == CMD_READ) && bank_active[BANK_SEL];
  assign wr_cmd_ok = (cmd == CMD_WRITE) && bank_active[BANK_SEL];
  assign close_hit = (cmd == CMD_CLOSE) && (ADDR[`A_PRE] || BANK_SEL == b_bank);
  assign last_word = !full_page && (b_idx == col_mask(mode_reg[`F_BL]));

  // read word fetch; a new read, a write or a close cuts the running read
  assign rv = run && (rd_cmd_ok || (rd_busy && !wr_cmd_ok && !close_hit));
  assign raddr = rd_cmd_ok ? {BANK_SEL, ADDR[`A_COL]} :
                 {b_bank, burst_col(b_start, b_idx, mode_reg[`F_BL], mode_reg[`F_IL])};

  // write word capture; a read ends input capture at once
  assign wv = run && (wr_cmd_ok || (wr_busy && !rd_cmd_ok && !close_hit));
  assign waddr = wr_cmd_ok ? {BANK_SEL, ADDR[`A_COL]} :
                 {b_bank, burst_col(b_start, b_idx, mode_reg[`F_BL], mode_reg[`F_IL])};

  sdram_store store
  (
    .clk(CLOCK),
    .we(wv),
    .be(~DQM),
    .waddr(waddr),
    .wdata(DQ_IN),
    .raddr(raddr),
    .rdata(mem_q)
  );

  // burst engine
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      rd_busy <= 1'b0;
      wr_busy <= 1'b0;
      b_bank <= 2'h0;
      b_start <= `ZERO8;
      b_idx <= `ZERO8;
      b_ap <= 1'b0;
    end
    else if (run)
    begin
      if (rd_cmd_ok || wr_cmd_ok)
      begin
        rd_busy <= rd_cmd_ok && (mode_reg[`F_BL] != `BL_1);
        wr_busy <= wr_cmd_ok && (mode_reg[`F_BL] != `BL_1);
        b_bank <= BANK_SEL;
        b_start <= ADDR[`A_COL];
        b_idx <= `ONE8;
        b_ap <= ADDR[`A_PRE] && !full_page;
      end
      else if (close_hit)
      begin
        rd_busy <= 1'b0;
        wr_busy <= 1'b0;
      end
      else if (rd_busy || wr_busy)
      begin
        b_idx <= b_idx + `ONE8;
        if (last_word)
        begin
          rd_busy <= 1'b0;
          wr_busy <= 1'b0;
        end
      end
    end
  end

  // automatic close after the final burst word
  always_comb
  begin
    ap_start = 1'b0;
    ap_start_bank = b_bank;
    if ((rd_cmd_ok || wr_cmd_ok) && ADDR[`A_PRE] && mode_reg[`F_BL] == `BL_1)
    begin
      ap_start = 1'b1;
      ap_start_bank = BANK_SEL;
    end
    else if ((rd_busy || wr_busy) && last_word && b_ap && !close_hit && !rd_cmd_ok && !wr_cmd_ok)
    begin
      ap_start = 1'b1;
    end
  end

  assign ap_close = ap_on && (ap_cnt == `ZERO8);

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      ap_on <= 1'b0;
      ap_cnt <= `ZERO8;
      ap_bank <= 2'h0;
    end
    else if (run)
    begin
      if (ap_start)
      begin
        ap_on <= 1'b1;
        ap_cnt <= ap_delay;
        ap_bank <= ap_start_bank;
      end
      else if (ap_close)
      begin
        ap_on <= 1'b0;
      end
      else if (ap_on)
      begin
        ap_cnt <= ap_cnt - `ONE8;
      end
    end
  end

  // per-bank row state
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      bank_active <= `ZERO4;
      for (int i = 0; i < 4; i++)
      begin
        open_row[i] <= `ZERO12;
      end
    end
    else if (run)
    begin
      if (cmd == CMD_OPEN && !bank_active[BANK_SEL])
      begin
        bank_active[BANK_SEL] <= 1'b1;
        open_row[BANK_SEL] <= ADDR;
      end
      else if (cmd == CMD_CLOSE && ADDR[`A_PRE])
      begin
        bank_active <= `ZERO4;
      end
      else if (cmd == CMD_CLOSE)
      begin
        bank_active[BANK_SEL] <= 1'b0;
      end
      if (ap_close && !(cmd == CMD_OPEN && BANK_SEL == ap_bank))
      begin
        bank_active[ap_bank] <= 1'b0;
      end
    end
  end

  // read latency pipe and output drivers, frozen while suspended
  assign out_v = (mode_reg[`F_CL] == `CL3) ? p2_v : p1_v;
  assign out_d = (mode_reg[`F_CL] == `CL3) ? p2_d : p1_d;

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      p1_v <= 1'b0;
      p2_v <= 1'b0;
      p1_d <= `ZERO32;
      p2_d <= `ZERO32;
      dqm_d1 <= `ONES4;
      DQ_OUT <= `ZERO32;
      DQ_OE_N <= `ONES4;
    end
    else if (run)
    begin
      p1_v <= rv;
      p1_d <= mem_q;
      p2_v <= p1_v;
      p2_d <= p1_d;
      dqm_d1 <= DQM;
      DQ_OUT <= out_d;
      for (int i = 0; i < 4; i++)
      begin
        DQ_OE_N[i] <= !(out_v && !dqm_d1[i]);
      end
    end
  end

  // power state
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      power <= PW_RUN;
    end
    else
    begin
      case (power)
        PW_RUN:
        begin
          if (cke_prev && !CKE)
          begin
            if (rd_busy || wr_busy || p1_v || p2_v)
            begin
              power <= PW_SUSPEND;
            end
            else
            begin
              power <= PW_DOWN;
            end
          end
        end
        PW_SUSPEND, PW_DOWN:
        begin
          if (!cke_prev && CKE)
          begin
            power <= PW_RUN;
          end
        end
        default:
        begin
          power <= PW_RUN;
        end
      endcase
    end
  end

  // apb slave, one wait state
  assign apb_take = PSEL && PENABLE && PREADY;
  assign status_word = {24'h00_0000, wr_busy, rd_busy, power == PW_DOWN,
                        power == PW_SUSPEND, bank_active};

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      PREADY <= 1'b0;
      PRDATA <= `ZERO32;
      PSLVERR <= 1'b0;
    end
    else if (PSEL && PENABLE && !PREADY)
    begin
      PREADY <= 1'b1;
      PSLVERR <= 1'b0;
      PRDATA <= `ZERO32;
      if (PADDR == `ADDR_MODE)
      begin
        PRDATA <= {26'h000_0000, mode_reg};
      end
      else if (PADDR == `ADDR_AP_DELAY)
      begin
        PRDATA <= {24'h00_0000, ap_delay};
      end
      else if (PADDR == `ADDR_STATUS)
      begin
        PRDATA <= status_word;
      end
      else
      begin
        PSLVERR <= 1'b1;
      end
    end
    else
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
    begin
      mode_reg <= `MODE_RESET;
      ap_delay <= `AP_DELAY_RESET;
    end
    else if (apb_take && PWRITE)
    begin
      if (PADDR == `ADDR_MODE)
      begin
        mode_reg <= PWDATA[`MODE_W-1:0];
      end
      else if (PADDR == `ADDR_AP_DELAY)
      begin
        ap_delay <= PWDATA[7:0];
      end
    end
  end

endmodule

//--- design/sdram_defines.svh
`ifndef SDRAM_DEFINES_SVH
`define SDRAM_DEFINES_SVH

// apb register byte addresses
`define ADDR_MODE 12'h000
`define ADDR_AP_DELAY 12'h004
`define ADDR_STATUS 12'h008

// mode register fields
`define F_CL 1:0
`define F_BL 4:2
`define F_IL 5
`define MODE_W 6
`define MODE_RESET 6'h0A
`define AP_DELAY_RESET 8'h02

// latency and burst length codes
`define CL3 2'h3
`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_FULL 3'h7

// column masks per burst length
`define MASK_1 8'h00
`define MASK_2 8'h01
`define MASK_4 8'h03
`define MASK_8 8'h07
`define MASK_FULL 8'hFF

// status register fields
`define S_BANKS 3:0
`define S_SUSPEND 4
`define S_DOWN 5
`define S_RD 6
`define S_WR 7

// pin fields
`define A_COL 7:0
`define A_PRE 10

// misc
`define ZERO32 32'h0000_0000
`define ZERO8 8'h00
`define ONE8 8'h01
`define ZERO12 12'h000
`define ZERO4 4'h0
`define ONES4 4'hF
`define STORE_DEPTH 1024

`endif

//--- design/sdram_pkg.sv
package sdram_pkg;

  typedef enum logic [2:0]
  {
    CMD_NOP = 3'b000,
    CMD_OPEN = 3'b001,
    CMD_CLOSE = 3'b010,
    CMD_READ = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_OTHER = 3'b101
  } cmd_t;

  typedef enum logic [1:0]
  {
    PW_RUN = 2'b00,
    PW_SUSPEND = 2'b01,
    PW_DOWN = 2'b10
  } power_t;

endpackage

//--- design/sdram_store.sv
`timescale 1ns/10ps
`include "sdram_defines.svh"

// word store, byte-lane writes, combinational read
module sdram_store
(
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [9:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [9:0] raddr,
  output logic [31:0] rdata
);

  logic [31:0] mem [0:`STORE_DEPTH-1];

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (we && be[i])
      begin
        mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
  end

  assign rdata = mem[raddr];

endmodule

//--- verification/sdram_bct_asserts.sv
`timescale 1ns/10ps
module sdram_bct_asserts
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [3:0] DQM,
  input wire logic [31:0] DQ_OUT,
  input wire logic [3:0] DQ_OE_N
);
  logic [5:0] mode;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // shadow of the mode register, for latency and burst length
  always_ff @(posedge CLOCK)
  begin
    if (!RESETN)
      mode <= 6'h0A;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000)
      mode <= PWDATA[5:0];
  end

  sequence rd_take;
    $past(CKE) && CKE && !CS_N && RAS_N && !CAS_N && WE_N && mode[1:0] != 2'h3;
  endsequence
  sequence quiet;
    CKE && (CS_N || (RAS_N && CAS_N && WE_N));
  endsequence

  rst_idle_a: assert property ($rose(RESETN) |-> DQ_OE_N == 4'hF && PRDATA == 32'h0000_0000)
    else $error("outputs not idle after reset");
  rd_first_a: assert property (rd_take ##0 (DQM == 4'h0) ##1 quiet |=> DQ_OE_N == 4'h0)
    else $error("first read word late");
  rd_release_a: assert property (rd_take ##0 (mode[4:2] == 3'h2) ##1 quiet[*5]
    |=> DQ_OE_N == 4'hF)
    else $error("data pins not released");
  mask_lat_a: assert property (CKE[*4] |-> (~DQ_OE_N & $past(DQM, 2)) == 4'h0)
    else $error("masked lane driven");
  freeze_a: assert property (!CKE ##1 RESETN |=> $stable(DQ_OUT) && $stable(DQ_OE_N))
    else $error("outputs moved while suspended");
  apb_ready_a: assert property (PSEL && $rose(PENABLE) |=> PREADY ##1 !PREADY)
    else $error("bus answer timing wrong");
  err_map_a: assert property (PREADY |-> PSLVERR == !(PADDR inside {12'h000, 12'h004, 12'h008}))
    else $error("error flag wrong for address");
  err_data_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
    else $error("refused read returned data");
endmodule

//--- verification/sdram_ctrl_model.sv
`timescale 1ns/10ps
module sdram_ctrl_model
(
  input wire logic clk,
  output logic cke,
  output logic [3:0] cmd,
  output logic [1:0] bank,
  output logic [11:0] addr,
  output logic [3:0] dqm,
  output logic [31:0] dq
);
  initial
  begin
    cke = 1'b1;
    cmd = 4'h7;
    bank = 2'h0;
    addr = 12'h000;
    dqm = 4'h0;
    dq = 32'h0000_0000;
  end

  // cmd is {select, row, column, write} strobes; one command edge then gap edges
  task automatic drive(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
    input logic [31:0] d, input int gap);
    cmd <= c;
    bank <= b;
    addr <= a;
    dq <= d;
    @(posedge clk);
    repeat (gap)
    begin
      cmd <= 4'h7;
      dq <= ~dq;
      @(posedge clk);
    end
  endtask
endmodule

//--- verification/sdram_bank_command_timing_tb_top.sv
`timescale 1ns/10ps
module sdram_bank_command_timing_tb_top;
  logic CLOCK = 1'b0;
  logic RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CKE, err;
  logic [11:0] PADDR, ADDR;
  logic [31:0] PWDATA, PRDATA, DQ_IN, DQ_OUT, rd, r;
  logic [31:0] w [4];
  logic [3:0] cmd, DQM, DQ_OE_N, m;
  logic [1:0] BANK_SEL;
  int errors, samples_checked, seed;

  always #10 CLOCK = ~CLOCK;

  sdram_ctrl_model i_ctrl (.clk(CLOCK), .cke(CKE), .cmd(cmd), .bank(BANK_SEL), .addr(ADDR),
    .dqm(DQM), .dq(DQ_IN));
  sdram_bank_command_timing i_dut (.CLOCK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .CKE, .CS_N(cmd[3]), .RAS_N(cmd[2]), .CAS_N(cmd[1]),
    .WE_N(cmd[0]), .BANK_SEL, .ADDR, .DQM, .DQ_IN, .DQ_OUT, .DQ_OE_N);

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  function automatic logic [31:0] lanes(input logic [3:0] k);
    return {{8{~k[3]}}, {8{~k[2]}}, {8{~k[1]}}, {8{~k[0]}}};
  endfunction

  task automatic results;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      chk("pready", 1'b1, 1'b0);
      results;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic stat(input logic [3:0] e);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("banks", {28'h000_0000, e}, rd & 32'h0000_000F);
  endtask

  initial
  begin
    RESETN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    errors = 0;
    samples_checked = 0;
    seed = 32'hbbe6;
    repeat (5) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLOCK);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("mode", 32'h0000_000A, rd);
    apb(1'b1, 12'h004, 32'h0000_0005);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("delay", 32'h0000_0005, rd);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("slverr", 1'b1, err);
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      i_ctrl.dqm <= 4'h0;
      i_ctrl.drive(4'h3, r[1:0], r[31:20], r, 2);
      stat(4'h1 << r[1:0]);
      for (int i = 0; i < 4; i++)
      begin
        w[i] = $random(seed);
        i_ctrl.drive((i == 0) ? 4'h4 : 4'h7, r[1:0], {4'h0, r[7:0]}, w[i], (i == 3) ? 2 : 0);
      end
      m = (k == 0) ? 4'h0 : r[11:8];
      i_ctrl.dqm <= m;
      fork
        i_ctrl.drive(4'h5, r[1:0], {4'h0, r[7:0]}, r, 7);
        for (int i = -2; i < 5; i++)
        begin
          @(negedge CLOCK);
          if (i == 4)
            chk("oe end", 4'hF, DQ_OE_N);
          else if (i >= 0)
          begin
            chk("oe", m, DQ_OE_N);
            chk("dq", w[i] & lanes(m), DQ_OUT & lanes(m));
          end
        end
      join
      i_ctrl.drive(4'h2, r[1:0], 12'h000, r, 2);
      stat(4'h0);
    end
    i_ctrl.dqm <= 4'h0;
    i_ctrl.drive(4'h3, 2'h0, 12'h000, r, 2);
    i_ctrl.drive(4'h3, 2'h3, 12'h000, r, 2);
    i_ctrl.drive(4'hD, 2'h0, 12'h000, r, 0);
    repeat (4)
    begin
      @(negedge CLOCK);
      chk("deselect", 4'hF, DQ_OE_N);
    end
    @(posedge CLOCK);
    stat(4'h9);
    i_ctrl.drive(4'h2, 2'h1, 12'h400, r, 2);
    stat(4'h0);
    i_ctrl.drive(4'h3, 2'h2, 12'h000, r, 2);
    i_ctrl.drive(4'h5, 2'h2, 12'h000, r, 1);
    i_ctrl.cke <= 1'b0;
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("suspend", 1'b1, rd[4]);
    i_ctrl.cke <= 1'b1;
    repeat (8) @(posedge CLOCK);
    i_ctrl.cke <= 1'b0;
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("down", 1'b1, rd[5]);
    i_ctrl.cke <= 1'b1;
    repeat (2) @(posedge CLOCK);
    // write with auto close: bank stays open until delay after last word
    i_ctrl.drive(4'h4, 2'h2, 12'h400, r, 3);
    stat(4'h4);
    repeat (4) @(posedge CLOCK);
    stat(4'h0);
    results;
  end
endmodule

bind sdram_bank_command_timing sdram_bct_asserts i_chk (.CLOCK, .RESETN, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N,
  .DQM, .DQ_OUT, .DQ_OE_N);
